//--- core/cpu8_alu_pkg.sv
package cpu8_alu_pkg;

  // ---------------------------------------------------------------
  // condition flag field positions
  // ---------------------------------------------------------------
  localparam int FLAG_HALF = 4;
  localparam int FLAG_IMASK = 3;
  localparam int FLAG_NEG = 2;
  localparam int FLAG_CARRY = 1;
  localparam int FLAG_ZERO = 0;
  localparam logic [7:0] FLAG_RSVD_MASK = 8'he0;
  localparam logic [7:0] FLAG_RESET = 8'h08;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_PTR = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ILLEGAL = 1;
  localparam int STAT_OPC_LSB = 8;

  // ---------------------------------------------------------------
  // opcode fields
  // ---------------------------------------------------------------
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_ADD = 4'hb;
  localparam logic [3:0] LO_AND = 4'h4;
  localparam logic [3:0] LO_ASL = 4'h8;
  localparam logic [3:0] LO_ASR = 4'h7;
  localparam logic [3:0] HI_LITERAL = 4'ha;
  localparam logic [3:0] HI_PAGE_ZERO = 4'hb;
  localparam logic [3:0] HI_FULL_ADDR = 4'hc;
  localparam logic [3:0] HI_NO_OFS = 4'hf;
  localparam logic [3:0] HI_BYTE_OFS = 4'he;
  localparam logic [3:0] HI_WORD_OFS = 4'hd;
  localparam logic [3:0] HI_SH_ACC = 4'h4;
  localparam logic [3:0] HI_SH_PTR = 4'h5;
  localparam logic [3:0] HI_SH_PAGE_ZERO = 4'h3;
  localparam logic [3:0] HI_SH_NO_OFS = 4'h7;
  localparam logic [3:0] HI_SH_BYTE_OFS = 4'h6;
  localparam logic [7:0] PAGE_ZERO_HIGH = 8'h00;

  // ---------------------------------------------------------------
  // cycle counts per mode
  // ---------------------------------------------------------------
  localparam logic [2:0] CYC_LITERAL = 3'h2;
  localparam logic [2:0] CYC_PAGE_ZERO = 3'h3;
  localparam logic [2:0] CYC_FULL_ADDR = 3'h4;
  localparam logic [2:0] CYC_NO_OFS = 3'h3;
  localparam logic [2:0] CYC_BYTE_OFS = 3'h4;
  localparam logic [2:0] CYC_WORD_OFS = 3'h5;
  localparam logic [2:0] CYC_SH_REG = 3'h3;
  localparam logic [2:0] CYC_SH_PAGE_ZERO = 3'h5;
  localparam logic [2:0] CYC_SH_NO_OFS = 3'h5;
  localparam logic [2:0] CYC_SH_BYTE_OFS = 3'h6;
  localparam logic [2:0] CYC_ILLEGAL = 3'h1;

  typedef enum {
    OPK_NONE, OPK_ADC, OPK_ADD, OPK_AND, OPK_ASL, OPK_ASR
  } cpu8_op_t;

  typedef enum {
    MODE_NONE, MODE_LITERAL, MODE_PAGE_ZERO, MODE_FULL_ADDR,
    MODE_NO_OFS, MODE_BYTE_OFS, MODE_WORD_OFS, MODE_IMPL_ACC,
    MODE_IMPL_PTR
  } cpu8_mode_t;

  // request from the sequencer: opcode, operand bytes, fetched byte
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] oper_first;
    logic [7:0] oper_second;
    logic [7:0] mem_data;
  } cpu8_req_t;

  // answer towards the memory side
  typedef struct packed {
    logic [15:0] eff_addr;
    logic mem_wr;
    logic [7:0] mem_wdata;
  } cpu8_mem_t;

endpackage

//--- core/cpu8_alu.sv
`timescale 1ns/10ps

module cpu8_alu (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic req_valid,
  input wire cpu8_alu_pkg::cpu8_req_t req,
  output logic req_ready,
  output logic done,
  output cpu8_alu_pkg::cpu8_mem_t mem_out,
  output logic [15:0] branch_disp
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic cpu8_alu_pkg::cpu8_op_t op_of(
    input logic [7:0] opc
  );
    logic [3:0] hi;
    logic [3:0] lo;
    hi = opc[7:4];
    lo = opc[3:0];
    op_of = cpu8_alu_pkg::OPK_NONE;
    if (hi == cpu8_alu_pkg::HI_LITERAL ||
        hi == cpu8_alu_pkg::HI_PAGE_ZERO ||
        hi == cpu8_alu_pkg::HI_FULL_ADDR ||
        hi == cpu8_alu_pkg::HI_NO_OFS ||
        hi == cpu8_alu_pkg::HI_BYTE_OFS ||
        hi == cpu8_alu_pkg::HI_WORD_OFS) begin
      if (lo == cpu8_alu_pkg::LO_ADC) begin
        op_of = cpu8_alu_pkg::OPK_ADC;
      end else if (lo == cpu8_alu_pkg::LO_ADD) begin
        op_of = cpu8_alu_pkg::OPK_ADD;
      end else if (lo == cpu8_alu_pkg::LO_AND) begin
        op_of = cpu8_alu_pkg::OPK_AND;
      end
    end else if (hi == cpu8_alu_pkg::HI_SH_ACC ||
                 hi == cpu8_alu_pkg::HI_SH_PTR ||
                 hi == cpu8_alu_pkg::HI_SH_PAGE_ZERO ||
                 hi == cpu8_alu_pkg::HI_SH_NO_OFS ||
                 hi == cpu8_alu_pkg::HI_SH_BYTE_OFS) begin
      if (lo == cpu8_alu_pkg::LO_ASL) begin
        op_of = cpu8_alu_pkg::OPK_ASL;
      end else if (lo == cpu8_alu_pkg::LO_ASR) begin
        op_of = cpu8_alu_pkg::OPK_ASR;
      end
    end
  endfunction

  // mode follows the high nibble, split by arithmetic or shift group
  function automatic cpu8_alu_pkg::cpu8_mode_t mode_of(
    input logic [7:0] opc
  );
    logic shift_grp;
    shift_grp = (opc[3:0] == cpu8_alu_pkg::LO_ASL) ||
                (opc[3:0] == cpu8_alu_pkg::LO_ASR);
    mode_of = cpu8_alu_pkg::MODE_NONE;
    if (op_of(opc) == cpu8_alu_pkg::OPK_NONE) begin
      mode_of = cpu8_alu_pkg::MODE_NONE;
    end else if (!shift_grp) begin
      case (opc[7:4])
        cpu8_alu_pkg::HI_LITERAL: mode_of = cpu8_alu_pkg::MODE_LITERAL;
        cpu8_alu_pkg::HI_PAGE_ZERO: mode_of = cpu8_alu_pkg::MODE_PAGE_ZERO;
        cpu8_alu_pkg::HI_FULL_ADDR: mode_of = cpu8_alu_pkg::MODE_FULL_ADDR;
        cpu8_alu_pkg::HI_NO_OFS: mode_of = cpu8_alu_pkg::MODE_NO_OFS;
        cpu8_alu_pkg::HI_BYTE_OFS: mode_of = cpu8_alu_pkg::MODE_BYTE_OFS;
        cpu8_alu_pkg::HI_WORD_OFS: mode_of = cpu8_alu_pkg::MODE_WORD_OFS;
        default: mode_of = cpu8_alu_pkg::MODE_NONE;
      endcase
    end else begin
      case (opc[7:4])
        cpu8_alu_pkg::HI_SH_ACC: mode_of = cpu8_alu_pkg::MODE_IMPL_ACC;
        cpu8_alu_pkg::HI_SH_PTR: mode_of = cpu8_alu_pkg::MODE_IMPL_PTR;
        cpu8_alu_pkg::HI_SH_PAGE_ZERO:
          mode_of = cpu8_alu_pkg::MODE_PAGE_ZERO;
        cpu8_alu_pkg::HI_SH_NO_OFS: mode_of = cpu8_alu_pkg::MODE_NO_OFS;
        cpu8_alu_pkg::HI_SH_BYTE_OFS: mode_of = cpu8_alu_pkg::MODE_BYTE_OFS;
        default: mode_of = cpu8_alu_pkg::MODE_NONE;
      endcase
    end
  endfunction

  // total cycles of an instruction, the accepting cycle included
  function automatic logic [2:0] cycles_of(input logic [7:0] opc);
    logic shift_grp;
    shift_grp = (op_of(opc) == cpu8_alu_pkg::OPK_ASL) ||
                (op_of(opc) == cpu8_alu_pkg::OPK_ASR);
    case (mode_of(opc))
      cpu8_alu_pkg::MODE_LITERAL: cycles_of = cpu8_alu_pkg::CYC_LITERAL;
      cpu8_alu_pkg::MODE_FULL_ADDR: cycles_of = cpu8_alu_pkg::CYC_FULL_ADDR;
      cpu8_alu_pkg::MODE_WORD_OFS: cycles_of = cpu8_alu_pkg::CYC_WORD_OFS;
      cpu8_alu_pkg::MODE_IMPL_ACC: cycles_of = cpu8_alu_pkg::CYC_SH_REG;
      cpu8_alu_pkg::MODE_IMPL_PTR: cycles_of = cpu8_alu_pkg::CYC_SH_REG;
      cpu8_alu_pkg::MODE_PAGE_ZERO:
        cycles_of = shift_grp ? cpu8_alu_pkg::CYC_SH_PAGE_ZERO
                              : cpu8_alu_pkg::CYC_PAGE_ZERO;
      cpu8_alu_pkg::MODE_NO_OFS:
        cycles_of = shift_grp ? cpu8_alu_pkg::CYC_SH_NO_OFS
                              : cpu8_alu_pkg::CYC_NO_OFS;
      cpu8_alu_pkg::MODE_BYTE_OFS:
        cycles_of = shift_grp ? cpu8_alu_pkg::CYC_SH_BYTE_OFS
                              : cpu8_alu_pkg::CYC_BYTE_OFS;
      default: cycles_of = cpu8_alu_pkg::CYC_ILLEGAL;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] accumulator_reg;
  logic [7:0] pointer_reg;
  logic [7:0] condition_flags_reg;
  logic [2:0] busy_cnt;
  logic illegal_seen;
  logic [7:0] last_opcode;
  logic accept;
  cpu8_alu_pkg::cpu8_op_t dec_op;
  cpu8_alu_pkg::cpu8_mode_t dec_mode;
  logic [7:0] operand;
  logic [7:0] result;
  logic [15:0] next_eff_addr;
  logic [7:0] next_acc;
  logic [7:0] next_ptr;
  logic [7:0] next_flags;
  logic next_mem_wr;
  logic [8:0] sum;

  assign req_ready = (busy_cnt == 3'h0);
  assign accept = req_valid && req_ready;
  assign dec_op = op_of(req.opcode);
  assign dec_mode = mode_of(req.opcode);

  // ---------------------------------------------------------------
  // effective address
  // ---------------------------------------------------------------
  // pointer offsets are unsigned; word sums wrap at 16 bits
  always_comb begin
    case (dec_mode)
      cpu8_alu_pkg::MODE_PAGE_ZERO:
        next_eff_addr = {cpu8_alu_pkg::PAGE_ZERO_HIGH,
                         req.oper_first};
      cpu8_alu_pkg::MODE_FULL_ADDR:
        next_eff_addr = {req.oper_first, req.oper_second};
      cpu8_alu_pkg::MODE_NO_OFS:
        next_eff_addr = {8'h00, pointer_reg};
      cpu8_alu_pkg::MODE_BYTE_OFS:
        next_eff_addr = 16'({8'h00, pointer_reg} +
                            {8'h00, req.oper_first});
      cpu8_alu_pkg::MODE_WORD_OFS:
        next_eff_addr = 16'({8'h00, pointer_reg} +
                            {req.oper_first, req.oper_second});
      default: next_eff_addr = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // operand select and result
  // ---------------------------------------------------------------
  always_comb begin
    case (dec_mode)
      cpu8_alu_pkg::MODE_LITERAL: operand = req.oper_first;
      cpu8_alu_pkg::MODE_IMPL_ACC: operand = accumulator_reg;
      cpu8_alu_pkg::MODE_IMPL_PTR: operand = pointer_reg;
      default: operand = req.mem_data;
    endcase
  end

  always_comb begin
    sum = {1'b0, accumulator_reg} + {1'b0, operand};
    if (dec_op == cpu8_alu_pkg::OPK_ADC) begin
      sum = 9'(sum + {8'h00,
                condition_flags_reg[cpu8_alu_pkg::FLAG_CARRY]});
    end
    case (dec_op)
      cpu8_alu_pkg::OPK_ADC: result = sum[7:0];
      cpu8_alu_pkg::OPK_ADD: result = sum[7:0];
      cpu8_alu_pkg::OPK_AND: result = accumulator_reg & operand;
      cpu8_alu_pkg::OPK_ASL: result = {operand[6:0], 1'b0};
      cpu8_alu_pkg::OPK_ASR: result = {operand[7], operand[7:1]};
      default: result = accumulator_reg;
    endcase
  end

  // ---------------------------------------------------------------
  // flag update
  // ---------------------------------------------------------------
  // start from the stored flags so untouched bits keep their value
  always_comb begin
    next_flags = condition_flags_reg;
    if (dec_op != cpu8_alu_pkg::OPK_NONE) begin
      next_flags[cpu8_alu_pkg::FLAG_NEG] = result[7];
      next_flags[cpu8_alu_pkg::FLAG_ZERO] = (result == 8'h00);
    end
    if (dec_op == cpu8_alu_pkg::OPK_ADC ||
        dec_op == cpu8_alu_pkg::OPK_ADD) begin
      next_flags[cpu8_alu_pkg::FLAG_HALF] =
        (accumulator_reg[3] & operand[3]) | (operand[3] & ~result[3]) |
        (~result[3] & accumulator_reg[3]);
      next_flags[cpu8_alu_pkg::FLAG_CARRY] =
        (accumulator_reg[7] & operand[7]) | (operand[7] & ~result[7]) |
        (~result[7] & accumulator_reg[7]);
    end else if (dec_op == cpu8_alu_pkg::OPK_ASL) begin
      next_flags[cpu8_alu_pkg::FLAG_CARRY] = operand[7];
    end else if (dec_op == cpu8_alu_pkg::OPK_ASR) begin
      next_flags[cpu8_alu_pkg::FLAG_CARRY] = operand[0];
    end
  end

  // ---------------------------------------------------------------
  // destination select
  // ---------------------------------------------------------------
  always_comb begin
    next_acc = accumulator_reg;
    next_ptr = pointer_reg;
    next_mem_wr = 1'b0;
    case (dec_op)
      cpu8_alu_pkg::OPK_ADC,
      cpu8_alu_pkg::OPK_ADD,
      cpu8_alu_pkg::OPK_AND: next_acc = result;
      cpu8_alu_pkg::OPK_ASL,
      cpu8_alu_pkg::OPK_ASR: begin
        if (dec_mode == cpu8_alu_pkg::MODE_IMPL_ACC) begin
          next_acc = result;
        end else if (dec_mode == cpu8_alu_pkg::MODE_IMPL_PTR) begin
          next_ptr = result;
        end else begin
          next_mem_wr = 1'b1;
        end
      end
      default: next_acc = accumulator_reg;
    endcase
  end

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic rd_wait;
  logic bus_wr;

  assign bus_wr = ph_valid && ph_write;
  // reads take one wait state so hrdata can come from a flop
  assign hreadyout = !(ph_valid && !ph_write && !rd_wait);
  assign hresp = 1'b0;

  // address phase capture; hsize is not decoded, so every access is taken as a full word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  // read data formed during the wait state, after any earlier write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (ph_valid && !ph_write && !rd_wait) begin
      rd_wait <= 1'b1;
      case (ph_addr)
        cpu8_alu_pkg::OFS_ACC: hrdata <= {24'h000000, accumulator_reg};
        cpu8_alu_pkg::OFS_PTR: hrdata <= {24'h000000, pointer_reg};
        cpu8_alu_pkg::OFS_FLAGS:
          hrdata <= {24'h000000,
                     condition_flags_reg | cpu8_alu_pkg::FLAG_RSVD_MASK};
        cpu8_alu_pkg::OFS_STATUS: begin
          hrdata <= 32'h0000_0000;
          hrdata[cpu8_alu_pkg::STAT_BUSY] <= !req_ready;
          hrdata[cpu8_alu_pkg::STAT_ILLEGAL] <= illegal_seen;
          hrdata[cpu8_alu_pkg::STAT_OPC_LSB +: 8] <= last_opcode;
        end
        default: hrdata <= 32'h0000_0000;
      endcase
    end else begin
      rd_wait <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // architectural registers
  // ---------------------------------------------------------------
  // a bus write in the same cycle as an accept takes precedence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accumulator_reg <= cpu8_alu_pkg::ACC_RESET;
      pointer_reg <= cpu8_alu_pkg::PTR_RESET;
    end else begin
      if (bus_wr && ph_addr == cpu8_alu_pkg::OFS_ACC) begin
        accumulator_reg <= hwdata[7:0];
      end else if (accept) begin
        accumulator_reg <= next_acc;
      end
      if (bus_wr && ph_addr == cpu8_alu_pkg::OFS_PTR) begin
        pointer_reg <= hwdata[7:0];
      end else if (accept) begin
        pointer_reg <= next_ptr;
      end
    end
  end

  // only the five defined flag bits are stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      condition_flags_reg <= cpu8_alu_pkg::FLAG_RESET;
    end else if (bus_wr && ph_addr == cpu8_alu_pkg::OFS_FLAGS) begin
      condition_flags_reg <= hwdata[7:0] & ~cpu8_alu_pkg::FLAG_RSVD_MASK;
    end else if (accept) begin
      condition_flags_reg <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // instruction timing and memory answer
  // ---------------------------------------------------------------
  // hold off the next request for the instruction's full cycle count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cnt <= 3'h0;
      done <= 1'b0;
    end else if (accept) begin
      busy_cnt <= 3'(cycles_of(req.opcode) - 3'h1);
      done <= (cycles_of(req.opcode) == 3'h1);
    end else begin
      busy_cnt <= (busy_cnt == 3'h0) ? 3'h0 : 3'(busy_cnt - 3'h1);
      done <= (busy_cnt == 3'h1);
    end
  end

  // sticky illegal flag; a status write of one to its bit clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      illegal_seen <= 1'b0;
      last_opcode <= 8'h00;
    end else begin
      if (accept && dec_op == cpu8_alu_pkg::OPK_NONE) begin
        illegal_seen <= 1'b1;
      end else if (bus_wr && ph_addr == cpu8_alu_pkg::OFS_STATUS &&
                   hwdata[cpu8_alu_pkg::STAT_ILLEGAL]) begin
        illegal_seen <= 1'b0;
      end
      if (accept) begin
        last_opcode <= req.opcode;
      end
    end
  end

  // memory address and branch offset held per instruction; write strobe pulses for one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_out <= '0;
      branch_disp <= 16'h0000;
    end else if (accept) begin
      mem_out.eff_addr <= next_eff_addr;
      mem_out.mem_wr <= next_mem_wr;
      mem_out.mem_wdata <= next_mem_wr ? result : 8'h00;
      branch_disp <= {{8{req.oper_first[7]}}, req.oper_first};
    end else begin
      mem_out.mem_wr <= 1'b0;
    end
  end

endmodule

//--- tb/cpu8_alu_chk.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------
// port checker for the datapath
// ---------------------------------------------------------------
module cpu8_alu_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic req_valid,
  input wire cpu8_alu_pkg::cpu8_req_t req,
  input wire logic req_ready,
  input wire logic done,
  input wire cpu8_alu_pkg::cpu8_mem_t mem_out,
  input wire logic [15:0] branch_disp
);
  // accept strobe of the instruction port
  logic take;
  assign take = req_valid && req_ready;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_adc_literal: assert property (
    take && req.opcode == 8'ha9 |=> !done ##1 done)
    else $error("literal add with carry not done in two cycles");
  a_shift_reg: assert property (
    take && req.opcode inside {8'h47, 8'h48, 8'h57, 8'h58}
    |=> !done [*2] ##1 done)
    else $error("register shift not done in three cycles");
  a_word_ofs: assert property (
    take && req.opcode inside {8'hd4, 8'hd9, 8'hdb}
    |=> !done [*4] ##1 done)
    else $error("word offset form not done in five cycles");
  a_page_zero: assert property (
    take && req.opcode inside {8'hb4, 8'hb9, 8'hbb, 8'h37, 8'h38}
    |=> mem_out.eff_addr == {8'h00, $past(req.oper_first)})
    else $error("page zero address has a nonzero high byte");
  a_full_addr: assert property (
    take && req.opcode inside {8'hc4, 8'hc9, 8'hcb} |=>
    mem_out.eff_addr == {$past(req.oper_first), $past(req.oper_second)})
    else $error("full address bytes out of order");
  a_branch_disp: assert property (
    take |=> branch_disp ==
    {{8{$past(req.oper_first[7])}}, $past(req.oper_first)})
    else $error("displacement not sign extended");
  a_asl_mem: assert property (
    take && req.opcode == 8'h38 |=> mem_out.mem_wr &&
    mem_out.mem_wdata == {$past(req.mem_data[6:0]), 1'b0})
    else $error("memory shift left wrote a wrong byte");
  a_asr_mem: assert property (
    take && req.opcode == 8'h37 |=> mem_out.mem_wr && mem_out.mem_wdata
    == {$past(req.mem_data[7]), $past(req.mem_data[7:1])})
    else $error("memory shift right lost the sign bit");
  a_read_wait: assert property (
    hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
    else $error("bus read wait state missing");

  c_word_adc: cover property (take && req.opcode == 8'hd9);
  c_byte_asl: cover property (take && req.opcode == 8'h68);
  c_done: cover property (done);
endmodule

bind cpu8_alu cpu8_alu_chk chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .done(done), .mem_out(mem_out),
  .branch_disp(branch_disp));

//--- tb/cpu8_seq_model.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------
// sequencer model: offers one instruction at a time
// ---------------------------------------------------------------
module cpu8_seq_model (
  input wire logic hclk,
  input wire logic req_ready,
  output logic req_valid,
  output cpu8_alu_pkg::cpu8_req_t req
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // holds the offer until taken, then shows a released pattern
  task automatic issue(input logic [7:0] op, b1, b2, m);
    @(posedge hclk);
    req_valid <= 1'b1;
    req <= {op, b1, b2, m};
    @(posedge hclk);
    while (req_ready !== 1'b1) @(posedge hclk);
    req_valid <= 1'b0;
    req <= ~{op, b1, b2, m};
  endtask
endmodule

//--- tb/tb_cpu8_add_logic_shift_alu.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------
// self-checking bench for the datapath
// ---------------------------------------------------------------
module tb_cpu8_add_logic_shift_alu;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, req_valid, req_ready, done;
  logic [31:0] hrdata, rd;
  logic [15:0] branch_disp;
  cpu8_alu_pkg::cpu8_req_t req;
  cpu8_alu_pkg::cpu8_mem_t mem_out;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000e247;

  always #5 hclk = ~hclk;

  // single slave: its hreadyout is the bus hready
  cpu8_alu dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .mem_out(mem_out),
    .branch_disp(branch_disp));
  cpu8_seq_model seq (.hclk(hclk), .req_ready(req_ready),
    .req_valid(req_valid), .req(req));

  // ---------------------------------------------------------------
  // expectation functions
  // ---------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // result byte and new low five flag bits
  function automatic logic [12:0] model(input logic [7:0] op, a, m, x, f);
    logic [7:0] o, r;
    logic [8:0] s;
    logic h, c;
    o = (op[7:4] == 4'h4) ? a : (op[7:4] == 4'h5) ? x : m;
    s = {1'b0, a} + {1'b0, m} + {8'h00, op[3:0] == 4'h9 && f[1]};
    h = f[4];
    c = f[1];
    case (op[3:0])
      4'h9, 4'hb: begin
        r = s[7:0];
        h = a[3] & m[3] | m[3] & ~r[3] | ~r[3] & a[3];
        c = a[7] & m[7] | m[7] & ~r[7] | ~r[7] & a[7];
      end
      4'h4: r = a & m;
      4'h8: begin
        r = {o[6:0], 1'b0};
        c = o[7];
      end
      default: begin
        r = {o[7], o[7:1]};
        c = o[0];
      end
    endcase
    return {r, h, f[3], r[7], c, r == 8'h00};
  endfunction

  function automatic int cyc(input logic [7:0] op);
    case (op[7:4])
      4'ha: return 2;
      4'hb, 4'hf, 4'h4, 4'h5: return 3;
      4'hc, 4'he: return 4;
      4'hd: return 5;
      4'h6: return 6;
      default: return 5;
    endcase
  endfunction

  function automatic logic [15:0] ea(input logic [7:0] op, x, b1, b2);
    case (op[7:4])
      4'hb, 4'h3: return {8'h00, b1};
      4'hc: return {b1, b2};
      4'he, 4'h6: return {8'h00, x} + {8'h00, b1};
      4'hd: return {8'h00, x} + {b1, b2};
      default: return {8'h00, x};
    endcase
  endfunction

  // every opcode of the five operations in turn
  function automatic logic [7:0] op_of(input int i);
    logic [3:0] h1 [6] = '{4'ha, 4'hb, 4'hc, 4'hf, 4'he, 4'hd};
    logic [3:0] h2 [5] = '{4'h4, 4'h5, 4'h3, 4'h7, 4'h6};
    logic [3:0] l1 [3] = '{4'h9, 4'hb, 4'h4};
    if (i < 18) return {h1[i % 6], l1[i / 6]};
    return {h2[(i - 18) % 5], (i < 23) ? 4'h8 : 4'h7};
  endfunction

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one instruction from loaded registers, then read accumulator, pointer and flags back
  task automatic run_one(input logic [7:0] op, input int rnd_no);
    logic [31:0] v, w;
    logic [7:0] a, x, b1, b2, m, f;
    logic [12:0] e;
    int n;
    v = rnd();
    w = rnd();
    {b2, b1, x, a} = v;
    {f, m} = w[15:0];
    if (rnd_no == 0) {a, m, x, b1, b2} = 40'h80_80_ff_80_ff;
    if (rnd_no == 1) {a, m, b1} = 24'h000000;
    // literal forms take the operand from the first operand byte
    if (op[7:4] == 4'ha) m = b1;
    ahb(1'b1, cpu8_alu_pkg::OFS_ACC, {24'h0, a}, v);
    ahb(1'b1, cpu8_alu_pkg::OFS_PTR, {24'h0, x}, v);
    ahb(1'b1, cpu8_alu_pkg::OFS_FLAGS, {24'h0, f}, v);
    seq.issue(op, b1, b2, m);
    #1;
    n = 0;
    while (done !== 1'b1 && n < 10) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk(n, cyc(op) - 1);
    e = model(op, a, m, x, f);
    chk(branch_disp, {{8{b1[7]}}, b1});
    if (!(op[7:4] inside {4'ha, 4'h4, 4'h5}))
      chk(mem_out.eff_addr, ea(op, x, b1, b2));
    if (op[7:4] inside {4'h3, 4'h6, 4'h7})
      chk(mem_out.mem_wdata, e[12:5]);
    ahb(1'b0, cpu8_alu_pkg::OFS_ACC, 32'h0, v);
    w = (op[3:0] inside {4'h7, 4'h8} && op[7:4] != 4'h4) ? a : e[12:5];
    chk(v, w);
    ahb(1'b0, cpu8_alu_pkg::OFS_PTR, 32'h0, v);
    chk(v, {24'h0, op[7:4] == 4'h5 ? e[12:5] : x});
    ahb(1'b0, cpu8_alu_pkg::OFS_FLAGS, 32'h0, v);
    chk(v, {24'h0, 3'b111, e[4:0]});
  endtask

  // ---------------------------------------------------------------
  // hang guard and main sequence
  // ---------------------------------------------------------------
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      give_verdict();
    end
  end

  // reset values, an unmapped word, then every opcode four times
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, cpu8_alu_pkg::OFS_ACC, 32'h0, rd);
    chk(rd, 32'h00000000);
    ahb(1'b0, cpu8_alu_pkg::OFS_FLAGS, 32'h0, rd);
    chk(rd, 32'h000000e8);
    ahb(1'b1, 8'h10, 32'h000000ff, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h00000000);
    // an undefined opcode changes no register but marks status, cleared by writing one
    seq.issue(8'h01, 8'h00, 8'h00, 8'h00);
    ahb(1'b0, cpu8_alu_pkg::OFS_STATUS, 32'h0, rd);
    chk(rd, 32'h00000102);
    ahb(1'b1, cpu8_alu_pkg::OFS_STATUS, 32'h00000002, rd);
    ahb(1'b0, cpu8_alu_pkg::OFS_STATUS, 32'h0, rd);
    chk(rd, 32'h00000100);
    chk({31'h0, hresp}, 32'h00000000);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 28; i++) run_one(op_of(i), r);
    end
    give_verdict();
  end
endmodule
